// ===== tsss_pkg.sv
package tsss_pkg;
  localparam longint unsigned CLK_HZ = 200_000_000;
  localparam longint unsigned CAP_HOLD_MS = 750;
  localparam longint unsigned LOCK_TIME_S = 180;
  localparam longint unsigned PARK_MAX_S = 45;
  localparam longint unsigned TIMEOUT_MS = 2500;
  localparam longint unsigned TIMEOUT_LONG_MS = 4000;
  localparam longint unsigned RAMP_TICK_MS = 10;
  localparam longint unsigned LANY_DECEL_MMPH_S = 2500;
  localparam longint unsigned LINK_DECEL_MMPH_S = 500;
  localparam longint unsigned CAP_CYC = (CAP_HOLD_MS * CLK_HZ + 999) / 1000;
  localparam longint unsigned LOCK_CYC = LOCK_TIME_S * CLK_HZ;
  localparam longint unsigned PARK_CYC = PARK_MAX_S * CLK_HZ;
  localparam longint unsigned TO_CYC = (TIMEOUT_MS * CLK_HZ + 999) / 1000;
  localparam longint unsigned TO_LONG_CYC = (TIMEOUT_LONG_MS * CLK_HZ + 999) / 1000;
  localparam longint unsigned TICK_CYC = RAMP_TICK_MS * CLK_HZ / 1000;
  localparam logic [15:0] LANY_STEP = 16'(LANY_DECEL_MMPH_S * RAMP_TICK_MS / 1000);
  localparam logic [15:0] LINK_STEP = 16'(LINK_DECEL_MMPH_S * RAMP_TICK_MS / 1000);
  localparam logic [7:0] REG_CTRL = 8'h00;
  localparam logic [7:0] REG_STATUS = 8'h04;
  localparam logic [7:0] REG_SPEED = 8'h08;
  localparam logic [7:0] REG_ELEV = 8'h0c;
  localparam int CTRL_LONG_BIT = 0;
  localparam logic CTRL_LONG_RST = 1'b0;
  localparam int STAT_ERR_BIT = 0;
  localparam int STAT_PARKF_BIT = 1;
  localparam int STAT_SESS_BIT = 2;
  localparam int STAT_LOCK_BIT = 3;
  localparam int STAT_STATE_LSB = 8;
  typedef enum logic [2:0] {CMD_NOP, CMD_OPEN, CMD_CLOSE, CMD_START, CMD_SET, CMD_STOP} tsss_cmd_e;
  typedef enum logic [2:0] {ST_IDLE, ST_RUN, ST_COAST, ST_RAMP, ST_LOCK, ST_PARK} tsss_state_e;
endpackage

// ===== tsss_top.sv
// Decided for this implementation: the strobed register port and the placing of the registers.
`timescale 1ns/1ps
module tsss_top
  import tsss_pkg::*;
#(
  parameter longint unsigned P_CAP_CYC = CAP_CYC,
  parameter longint unsigned P_LOCK_CYC = LOCK_CYC,
  parameter longint unsigned P_PARK_CYC = PARK_CYC,
  parameter longint unsigned P_TO_CYC = TO_CYC,
  parameter longint unsigned P_TO_LONG_CYC = TO_LONG_CYC,
  parameter longint unsigned P_TICK_CYC = TICK_CYC
)
(
  input wire logic CORE_CLK,
  input wire logic RESET,
  input wire logic RS_MSG_VALID,
  input wire logic [2:0] RS_MSG_CMD,
  input wire logic [15:0] RS_MSG_SPEED,
  input wire logic [7:0] RS_MSG_ELEV,
  input wire logic RS_LINK_UP,
  input wire logic USB_MSG_VALID,
  input wire logic [2:0] USB_MSG_CMD,
  input wire logic [15:0] USB_MSG_SPEED,
  input wire logic [7:0] USB_MSG_ELEV,
  input wire logic USB_LINK_UP,
  input wire logic EMERGENCY_STOP_BUTTON,
  input wire logic LANYARD_ATTACHED,
  input wire logic LANYARD_CAP_PRESSED,
  input wire logic ELEV_AT_ZERO,
  input wire logic PARK_CHECK_DONE,
  input wire logic [7:0] REG_ADDR,
  input wire logic [31:0] REG_WDATA,
  input wire logic REG_WR,
  input wire logic REG_RD,
  output logic [31:0] REG_RDATA,
  output logic BELT_DRIVE_EN,
  output logic [15:0] BELT_SPEED,
  output logic BELT_LOCK,
  output logic [7:0] ELEV_TARGET,
  output logic CONSOLE_KEYS_EN,
  output logic ERROR_MODE
);

  if (P_TICK_CYC < 1 || P_CAP_CYC < 1 || P_TO_CYC < 1 || P_TO_LONG_CYC < 1)
  begin : g_bad_count
    $error("tsss_top: counts must be at least one cycle");
  end
  if (P_LOCK_CYC >= (64'd1 << 40) || P_PARK_CYC >= (64'd1 << 40))
  begin : g_bad_wide
    $error("tsss_top: lock or park count exceeds counter width");
  end
  if (P_CAP_CYC >= (64'd1 << 32) || P_TO_LONG_CYC >= (64'd1 << 32))
  begin : g_bad_narrow
    $error("tsss_top: cap or timeout count exceeds counter width");
  end

  function automatic logic [15:0] sat_sub(input logic [15:0] a, input logic [15:0] b);
    sat_sub = (a > b) ? a - b : 16'h0000;
  endfunction

  tsss_state_e state_reg, state_next;
  logic msg_valid;
  tsss_cmd_e msg_cmd;
  logic [15:0] msg_speed;
  logic [7:0] msg_elev;
  logic session_reg;
  logic long_to_reg;
  logic [31:0] to_cnt_reg;
  logic [31:0] cap_cnt_reg;
  logic [31:0] tick_cnt_reg;
  logic [39:0] lock_cnt_reg;
  logic [39:0] park_cnt_reg;
  logic lany_src_reg;
  logic fast_reg;
  logic error_reg;
  logic park_fault_reg;
  logic [15:0] speed_reg;
  logic [7:0] elev_reg;
  logic [31:0] rdata_reg;
  logic cap_long, kill, link_lost, timed_out, link_bad, tick;
  logic lock_done, park_done, park_ok, start_cmd, start_early, start_ok;

  // serial wins a same-cycle collision; the usb message is dropped
  always_comb
  begin
    if (RS_MSG_VALID)
    begin
      msg_valid = 1'b1;
      msg_cmd = tsss_cmd_e'(RS_MSG_CMD);
      msg_speed = RS_MSG_SPEED;
      msg_elev = RS_MSG_ELEV;
    end
    else
    begin
      msg_valid = USB_MSG_VALID;
      msg_cmd = tsss_cmd_e'(USB_MSG_CMD);
      msg_speed = USB_MSG_SPEED;
      msg_elev = USB_MSG_ELEV;
    end
  end

  assign cap_long = cap_cnt_reg >= 32'(P_CAP_CYC);
  assign kill = !LANYARD_ATTACHED || cap_long;
  assign link_lost = session_reg && !(RS_LINK_UP || USB_LINK_UP);
  assign timed_out = session_reg
    && (to_cnt_reg >= (long_to_reg ? 32'(P_TO_LONG_CYC) : 32'(P_TO_CYC)));
  assign link_bad = link_lost || timed_out;
  assign tick = tick_cnt_reg == 32'(P_TICK_CYC - 1);
  assign lock_done = lock_cnt_reg >= 40'(P_LOCK_CYC);
  assign park_done = park_cnt_reg >= 40'(P_PARK_CYC);
  assign park_ok = ELEV_AT_ZERO && PARK_CHECK_DONE;
  assign start_cmd = msg_valid && msg_cmd == CMD_START;
  // a start during parking is early too, whatever the height sensor says
  assign start_early = start_cmd && !error_reg
    && (!ELEV_AT_ZERO || state_reg == ST_PARK);
  assign start_ok = start_cmd && !error_reg && !start_early && state_reg == ST_IDLE
    && !kill && !EMERGENCY_STOP_BUTTON && !link_bad;

  always_comb
  begin
    state_next = state_reg;
    if (EMERGENCY_STOP_BUTTON && state_reg != ST_COAST)
    begin
      state_next = ST_COAST;
    end
    else
    begin
      case (state_reg)
        ST_IDLE:
        begin
          if (kill)
            state_next = ST_LOCK;
          else if (start_ok)
            state_next = ST_RUN;
        end
        ST_RUN:
        begin
          if (kill || link_bad)
            state_next = ST_RAMP;
          else if (msg_valid && msg_cmd == CMD_STOP)
            state_next = ST_IDLE;
        end
        ST_COAST:
        begin
          if (!EMERGENCY_STOP_BUTTON)
            state_next = ST_PARK;
        end
        ST_RAMP:
        begin
          if (speed_reg == 16'h0000)
            state_next = ST_LOCK;
        end
        ST_LOCK:
        begin
          if (lany_src_reg && !kill)
            state_next = ST_PARK;
          else if (!lany_src_reg && lock_done)
            state_next = ST_IDLE;
        end
        ST_PARK:
        begin
          if (kill)
            state_next = ST_LOCK;
          else if (park_ok || park_done)
            state_next = ST_IDLE;
        end
        default: state_next = ST_IDLE;
      endcase
    end
  end

  always_ff @(posedge CORE_CLK)
  begin
    if (RESET)
      state_reg <= ST_IDLE;
    else
      state_reg <= state_next;
  end

  // lanyard source picks the fast ramp and the reattach exit
  always_ff @(posedge CORE_CLK)
  begin
    if (RESET)
    begin
      lany_src_reg <= 1'b0;
      fast_reg <= 1'b0;
    end
    else if (state_reg != ST_RAMP && state_reg != ST_LOCK && kill)
    begin
      lany_src_reg <= 1'b1;
      fast_reg <= 1'b1;
    end
    else if (state_reg == ST_RUN && link_bad)
    begin
      lany_src_reg <= 1'b0;
      fast_reg <= 1'b0;
    end
    else if (state_reg == ST_RAMP && kill)
    begin
      lany_src_reg <= 1'b1;
      fast_reg <= 1'b1;
    end
  end

  always_ff @(posedge CORE_CLK)
  begin
    if (RESET)
      speed_reg <= 16'h0000;
    else if (state_next == ST_RUN && state_reg == ST_IDLE)
      speed_reg <= msg_speed;
    else if (state_reg == ST_RUN && state_next == ST_RUN)
    begin
      if (msg_valid && msg_cmd == CMD_SET)
        speed_reg <= msg_speed;
    end
    else if (state_reg == ST_RAMP && state_next == ST_RAMP)
    begin
      if (tick)
        speed_reg <= sat_sub(speed_reg, fast_reg ? LANY_STEP : LINK_STEP);
    end
    else if (state_next != ST_RAMP)
      speed_reg <= 16'h0000;
  end

  always_ff @(posedge CORE_CLK)
  begin
    if (RESET)
      tick_cnt_reg <= 32'h0000_0000;
    else if (state_reg != ST_RAMP || tick)
      tick_cnt_reg <= 32'h0000_0000;
    else
      tick_cnt_reg <= tick_cnt_reg + 32'h0000_0001;
  end

  // elevation only moves in idle, run and park; stops hold it
  always_ff @(posedge CORE_CLK)
  begin
    if (RESET)
      elev_reg <= 8'h00;
    else if (state_next == ST_PARK)
      elev_reg <= 8'h00;
    else if (state_next == ST_RUN && state_reg == ST_IDLE)
      elev_reg <= msg_elev;
    else if ((state_reg == ST_RUN || state_reg == ST_IDLE) && state_next == state_reg
      && msg_valid && msg_cmd == CMD_SET)
      elev_reg <= msg_elev;
  end

  always_ff @(posedge CORE_CLK)
  begin
    if (RESET)
      error_reg <= 1'b0;
    else if (start_early)
      error_reg <= 1'b1;
  end

  always_ff @(posedge CORE_CLK)
  begin
    if (RESET)
      cap_cnt_reg <= 32'h0000_0000;
    else if (!LANYARD_CAP_PRESSED)
      cap_cnt_reg <= 32'h0000_0000;
    else if (!cap_long)
      cap_cnt_reg <= cap_cnt_reg + 32'h0000_0001;
  end

  always_ff @(posedge CORE_CLK)
  begin
    if (RESET)
      lock_cnt_reg <= 40'h00_0000_0000;
    else if (state_reg != ST_LOCK)
      lock_cnt_reg <= 40'h00_0000_0000;
    else if (!lock_done)
      lock_cnt_reg <= lock_cnt_reg + 40'h00_0000_0001;
  end

  always_ff @(posedge CORE_CLK)
  begin
    if (RESET)
      park_cnt_reg <= 40'h00_0000_0000;
    else if (state_reg != ST_PARK)
      park_cnt_reg <= 40'h00_0000_0000;
    else if (!park_done)
      park_cnt_reg <= park_cnt_reg + 40'h00_0000_0001;
  end

  // park left on the bound without a clean check is reported, not hidden
  always_ff @(posedge CORE_CLK)
  begin
    if (RESET)
      park_fault_reg <= 1'b0;
    else if (state_reg == ST_PARK && park_done && !park_ok)
      park_fault_reg <= 1'b1;
  end

  always_ff @(posedge CORE_CLK)
  begin
    if (RESET)
      session_reg <= 1'b0;
    else if (msg_valid && msg_cmd == CMD_OPEN)
      session_reg <= 1'b1;
    else if (msg_valid && msg_cmd == CMD_CLOSE)
      session_reg <= 1'b0;
  end

  always_ff @(posedge CORE_CLK)
  begin
    if (RESET)
      to_cnt_reg <= 32'h0000_0000;
    else if (msg_valid || !session_reg)
      to_cnt_reg <= 32'h0000_0000;
    else if (!timed_out)
      to_cnt_reg <= to_cnt_reg + 32'h0000_0001;
  end

  always_ff @(posedge CORE_CLK)
  begin
    if (RESET)
      long_to_reg <= CTRL_LONG_RST;
    else if (REG_WR && REG_ADDR == REG_CTRL)
      long_to_reg <= REG_WDATA[CTRL_LONG_BIT];
  end

  always_ff @(posedge CORE_CLK)
  begin
    if (RESET)
      rdata_reg <= 32'h0000_0000;
    else if (!REG_RD)
      rdata_reg <= 32'h0000_0000;
    else if (REG_ADDR == REG_CTRL)
      rdata_reg <= {31'h0000_0000, long_to_reg};
    else if (REG_ADDR == REG_STATUS)
    begin
      rdata_reg <= 32'h0000_0000;
      rdata_reg[STAT_ERR_BIT] <= error_reg;
      rdata_reg[STAT_PARKF_BIT] <= park_fault_reg;
      rdata_reg[STAT_SESS_BIT] <= session_reg;
      rdata_reg[STAT_LOCK_BIT] <= BELT_LOCK;
      rdata_reg[STAT_STATE_LSB +: 3] <= state_reg;
    end
    else if (REG_ADDR == REG_SPEED)
      rdata_reg <= {16'h0000, speed_reg};
    else if (REG_ADDR == REG_ELEV)
      rdata_reg <= {24'h00_0000, elev_reg};
    else
      rdata_reg <= 32'h0000_0000;
  end

  assign REG_RDATA = rdata_reg;
  assign BELT_DRIVE_EN = (state_reg == ST_RUN || state_reg == ST_RAMP) && !error_reg;
  assign BELT_SPEED = speed_reg;
  assign BELT_LOCK = state_reg == ST_LOCK && !lock_done;
  assign ELEV_TARGET = elev_reg;
  assign CONSOLE_KEYS_EN = !session_reg;
  assign ERROR_MODE = error_reg;

  default clocking cb @(posedge CORE_CLK); endclocking
  default disable iff (RESET);

  a_estop_coast_hold: assert property (EMERGENCY_STOP_BUTTON |=>
    !BELT_DRIVE_EN && ELEV_TARGET == $past(ELEV_TARGET))
    else $error("estop did not coast with elevation held");
  a_release_to_zero: assert property (state_reg == ST_COAST && !EMERGENCY_STOP_BUTTON
    |=> state_reg == ST_PARK && ELEV_TARGET == 8'h00)
    else $error("estop release did not park at zero grade");
  a_lany_ramp_step: assert property (state_reg == ST_RAMP && fast_reg && tick
    && !EMERGENCY_STOP_BUTTON && speed_reg > LANY_STEP
    |=> BELT_SPEED == $past(BELT_SPEED) - LANY_STEP)
    else $error("lanyard ramp step wrong");
  a_link_ramp_step: assert property (state_reg == ST_RAMP && !fast_reg && !kill && tick
    && !EMERGENCY_STOP_BUTTON && speed_reg > LINK_STEP
    |=> BELT_SPEED == $past(BELT_SPEED) - LINK_STEP)
    else $error("link loss ramp step wrong");
  a_lock_holds_belt: assert property (state_reg == ST_LOCK && !lock_done
    |-> BELT_LOCK && BELT_SPEED == 16'h0000 && !BELT_DRIVE_EN)
    else $error("belt not locked at zero");
  a_lock_elev_kept: assert property (state_reg == ST_LOCK && $past(state_reg) == ST_LOCK
    |-> ELEV_TARGET == $past(ELEV_TARGET))
    else $error("elevation moved during lock");
  a_reattach_parks: assert property (state_reg == ST_LOCK && lany_src_reg && !kill
    && !EMERGENCY_STOP_BUTTON |=> state_reg == ST_PARK ##0 ELEV_TARGET == 8'h00)
    else $error("reattach did not park");
  a_cap_threshold: assert property (LANYARD_CAP_PRESSED [*2] ##0
    cap_cnt_reg == 32'(P_CAP_CYC) - 32'h0000_0001 |=> kill)
    else $error("held cap did not kill");
  a_park_bounded: assert property (park_cnt_reg <= 40'(P_PARK_CYC))
    else $error("park ran past bound");
  a_early_start_err: assert property (start_cmd && !error_reg && !ELEV_AT_ZERO
    |=> ERROR_MODE && state_reg != ST_RUN)
    else $error("early start not rejected");
  a_error_no_belt: assert property (error_reg |-> !BELT_DRIVE_EN ##1 ERROR_MODE)
    else $error("error mode drove belt or cleared");
  a_timeout_restart: assert property (msg_valid |=> to_cnt_reg == 32'h0000_0000)
    else $error("timeout counter not restarted");
  a_run_timeout_ramp: assert property (state_reg == ST_RUN && timed_out && !kill
    && !EMERGENCY_STOP_BUTTON |=> state_reg == ST_RAMP && !fast_reg)
    else $error("timeout did not start slow ramp");
  a_keys_session: assert property (msg_valid && msg_cmd == CMD_OPEN |=> !CONSOLE_KEYS_EN)
    else $error("console keys live in session");

  c_lany_to_park: cover property (state_reg == ST_LOCK && lany_src_reg ##1 state_reg == ST_PARK);
  c_link_lock_done: cover property (state_reg == ST_LOCK && !lany_src_reg ##1 state_reg == ST_IDLE);
  c_error_entered: cover property (!error_reg ##1 error_reg);
  c_run_started: cover property (state_reg == ST_IDLE ##1 state_reg == ST_RUN);

endmodule // tsss_top

// ===== tsss_host_model.sv
`timescale 1ns/1ps
module tsss_host_model
  import tsss_pkg::*;
(
  input wire logic clk,
  output logic rs_valid,
  output logic usb_valid,
  output logic [2:0] msg_cmd,
  output logic [15:0] msg_speed,
  output logic [7:0] msg_elev,
  output logic rs_link,
  output logic usb_link
);
  logic pulse = 1'b0;
  logic on_usb = 1'b0;
  assign rs_valid = pulse & ~on_usb;
  assign usb_valid = pulse & on_usb;
  initial
  begin
    msg_cmd = 3'h0;
    msg_speed = 16'h0000;
    msg_elev = 8'h00;
    rs_link = 1'b1;
    usb_link = 1'b1;
  end
  // one message per call; start is sent whenever called, even during park
  task automatic send(input logic usb, input tsss_cmd_e cmd, input logic [15:0] spd,
                      input logic [7:0] el);
    @(posedge clk);
    on_usb <= usb;
    pulse <= 1'b1;
    msg_cmd <= cmd;
    msg_speed <= spd;
    msg_elev <= el;
    @(posedge clk);
    pulse <= 1'b0;
    // fields not held after the pulse, so stale values cannot pass
    msg_cmd <= ~cmd;
    msg_speed <= ~spd;
    msg_elev <= ~el;
  endtask
  // cable pulled or restored per port; one live port keeps the link
  task automatic set_link(input logic rs_up, input logic usb_up);
    rs_link <= rs_up;
    usb_link <= usb_up;
  endtask
endmodule // tsss_host_model

// ===== tb_treadmill_safety_stop_supervisor.sv
`timescale 1ns/1ps
`define CHK(got, exp, msg) \
  begin \
    checked++; \
    if ((got) !== (exp)) \
    begin \
      mismatches++; \
      $display("MISMATCH %0t %s", $time, msg); \
    end \
  end
module tb_treadmill_safety_stop_supervisor
  import tsss_pkg::*;
;
  localparam longint unsigned TO = 100;
  localparam longint unsigned TOL = 160;
  logic core_clk = 1'b0;
  logic reset = 1'b1;
  logic rs_v, usb_v, rs_up, usb_up;
  logic [2:0] m_cmd;
  logic [15:0] m_spd;
  logic [7:0] m_el;
  logic estop = 1'b0, lany_att = 1'b1, cap = 1'b0, at_zero = 1'b1, park_done = 1'b1;
  logic [7:0] reg_addr = 8'h00;
  logic [31:0] reg_wdata = 32'h00000000;
  logic reg_wr_s = 1'b0, reg_rd_s = 1'b0;
  logic [31:0] reg_rdata;
  logic drive_en, lock, keys_en, err_mode;
  logic [15:0] belt_speed;
  logic [7:0] elev_tgt;
  int mismatches = 0;
  int checked = 0;
  always #2.5 core_clk = ~core_clk;
  tsss_host_model host_u (.clk(core_clk), .rs_valid(rs_v), .usb_valid(usb_v), .msg_cmd(m_cmd),
    .msg_speed(m_spd), .msg_elev(m_el), .rs_link(rs_up), .usb_link(usb_up));
  tsss_top #(.P_CAP_CYC(20), .P_LOCK_CYC(200), .P_PARK_CYC(300), .P_TO_CYC(TO),
    .P_TO_LONG_CYC(TOL), .P_TICK_CYC(10)) dut_u (
    .CORE_CLK(core_clk), .RESET(reset), .RS_MSG_VALID(rs_v), .RS_MSG_CMD(m_cmd),
    .RS_MSG_SPEED(m_spd), .RS_MSG_ELEV(m_el), .RS_LINK_UP(rs_up), .USB_MSG_VALID(usb_v),
    .USB_MSG_CMD(m_cmd), .USB_MSG_SPEED(m_spd), .USB_MSG_ELEV(m_el), .USB_LINK_UP(usb_up),
    .EMERGENCY_STOP_BUTTON(estop), .LANYARD_ATTACHED(lany_att), .LANYARD_CAP_PRESSED(cap),
    .ELEV_AT_ZERO(at_zero), .PARK_CHECK_DONE(park_done), .REG_ADDR(reg_addr),
    .REG_WDATA(reg_wdata), .REG_WR(reg_wr_s), .REG_RD(reg_rd_s), .REG_RDATA(reg_rdata),
    .BELT_DRIVE_EN(drive_en), .BELT_SPEED(belt_speed), .BELT_LOCK(lock),
    .ELEV_TARGET(elev_tgt), .CONSOLE_KEYS_EN(keys_en), .ERROR_MODE(err_mode));
  task automatic complete_run();
    $display("checked %0d mismatches %0d", checked, mismatches);
    if (mismatches == 0 && checked > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask
  task automatic tick(input int n);
    repeat (n) @(posedge core_clk);
    #1;
  endtask
  task automatic reg_wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge core_clk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr_s <= 1'b1;
    @(posedge core_clk);
    reg_wr_s <= 1'b0;
  endtask
  task automatic reg_rd(input logic [7:0] a, output logic [31:0] d);
    @(posedge core_clk);
    reg_addr <= a;
    reg_rd_s <= 1'b1;
    @(posedge core_clk);
    reg_rd_s <= 1'b0;
    #1;
    d = reg_rdata;
  endtask
  // bounded wait until belt speed equals (eq) or leaves (not eq) a value
  task automatic wait_speed(input logic [15:0] v, input logic eq, input int lim, output int n);
    n = 0;
    while (((belt_speed === v) != eq) && n < lim)
    begin
      @(posedge core_clk);
      #1;
      n++;
    end
    if (n >= lim)
    begin
      mismatches++;
      complete_run();
    end
  endtask
  // reset stands in for a main power cycle
  task automatic do_reset();
    @(posedge core_clk);
    reset <= 1'b1;
    repeat (3) @(posedge core_clk);
    reset <= 1'b0;
    estop <= 1'b0;
    lany_att <= 1'b1;
    cap <= 1'b0;
    park_done <= 1'b1;
    at_zero <= 1'b1;
    host_u.set_link(1'b1, 1'b1);
    tick(1);
  endtask
  task automatic go_run(input logic usb, input logic [15:0] s, input logic [7:0] e);
    host_u.send(usb, CMD_OPEN, 16'h0000, 8'h00);
    host_u.send(usb, CMD_START, s, e);
    #1;
    `CHK({drive_en, belt_speed, elev_tgt}, {1'b1, s, e}, "start taken")
  endtask
  task automatic t_regs();
    logic [31:0] d;
    do_reset();
    `CHK({drive_en, lock, err_mode, keys_en}, 4'h1, "outputs after reset")
    reg_rd(REG_CTRL, d);
    `CHK(d, 32'h00000000, "ctrl reset value")
    reg_wr(REG_CTRL, 32'h00000001);
    reg_rd(REG_CTRL, d);
    `CHK(d, 32'h00000001, "ctrl long select")
    reg_rd(8'h10, d);
    `CHK(d, 32'h00000000, "unmapped read")
  endtask
  task automatic t_run();
    do_reset();
    host_u.send(1'b1, CMD_OPEN, 16'h0000, 8'h00);
    #1;
    `CHK(keys_en, 1'b0, "keys in session")
    host_u.send(1'b1, CMD_START, 16'h03e8, 8'h12);
    host_u.send(1'b0, CMD_SET, 16'h05dc, 8'h14);
    #1;
    `CHK({drive_en, belt_speed, elev_tgt}, {1'b1, 16'h05dc, 8'h14}, "set on other port")
    host_u.send(1'b1, CMD_CLOSE, 16'h0000, 8'h00);
    tick(150);
    `CHK({keys_en, belt_speed}, {1'b1, 16'h05dc}, "no timeout out of session")
    @(posedge core_clk);
    cap <= 1'b1;
    repeat (15) @(posedge core_clk);
    cap <= 1'b0;
    tick(15);
    `CHK(belt_speed, 16'h05dc, "short cap press ignored")
    @(posedge core_clk);
    cap <= 1'b1;
    repeat (40) @(posedge core_clk);
    cap <= 1'b0;
    #1;
    `CHK(belt_speed < 16'h05dc, 1'b1, "long cap press kills")
  endtask
  task automatic t_lanyard();
    int n;
    do_reset();
    go_run(1'b0, 16'h0064, 8'h20);
    @(posedge core_clk);
    lany_att <= 1'b0;
    wait_speed(16'h0000, 1'b1, 80, n);
    `CHK(n >= 20 && n <= 45, 1'b1, "kill ramp time")
    tick(3);
    `CHK({lock, drive_en, elev_tgt}, {2'b10, 8'h20}, "locked, elevation held")
    @(posedge core_clk);
    lany_att <= 1'b1;
    tick(2);
    `CHK(elev_tgt, 8'h00, "reattach parks")
  endtask
  task automatic t_link();
    int n;
    do_reset();
    go_run(1'b0, 16'h0032, 8'h10);
    @(posedge core_clk);
    host_u.set_link(1'b0, 1'b1);
    tick(10);
    `CHK({drive_en, belt_speed}, {1'b1, 16'h0032}, "one port down keeps running")
    @(posedge core_clk);
    host_u.set_link(1'b0, 1'b0);
    wait_speed(16'h0000, 1'b1, 200, n);
    `CHK(n >= 88 && n <= 106, 1'b1, "link loss ramp time")
    tick(3);
    `CHK({lock, elev_tgt}, {1'b1, 8'h10}, "link lock, elevation held")
    n = 0;
    while (lock === 1'b1 && n < 300)
    begin
      tick(1);
      n++;
    end
    `CHK(n >= 190 && n <= 205, 1'b1, "link lock length")
    @(posedge core_clk);
    host_u.set_link(1'b1, 1'b1);
    go_run(1'b1, 16'h0046, 8'h11);
  endtask
  task automatic t_timeout(input logic long_sel);
    int n;
    longint unsigned lim;
    do_reset();
    lim = long_sel ? TOL : TO;
    reg_wr(REG_CTRL, {31'h0, long_sel});
    go_run(1'b0, 16'h0014, 8'h05);
    tick(60);
    host_u.send(1'b0, CMD_NOP, 16'h0000, 8'h00);
    wait_speed(16'h0014, 1'b0, 400, n);
    `CHK(n >= int'(lim) && n <= int'(lim) + 14, 1'b1, "timeout after silence")
    wait_speed(16'h0000, 1'b1, 100, n);
    tick(3);
    `CHK({lock, elev_tgt}, {1'b1, 8'h05}, "timeout lock")
  endtask
  task automatic t_estop();
    logic [31:0] d;
    do_reset();
    @(posedge core_clk);
    park_done <= 1'b0;
    go_run(1'b1, 16'h012c, 8'h30);
    @(posedge core_clk);
    estop <= 1'b1;
    tick(1);
    `CHK({drive_en, elev_tgt}, {1'b0, 8'h30}, "coast, elevation held")
    @(posedge core_clk);
    estop <= 1'b0;
    tick(1);
    `CHK(elev_tgt, 8'h00, "release returns to zero")
    reg_rd(REG_STATUS, d);
    `CHK(d[10:8], 3'h5, "park after stop")
    @(posedge core_clk);
    park_done <= 1'b1;
    reg_rd(REG_STATUS, d);
    `CHK({d[10:8], d[1:0]}, 5'h00, "park ends on check")
    host_u.send(1'b1, CMD_START, 16'h0028, 8'h00);
    #1;
    `CHK({drive_en, err_mode}, 2'b10, "start after park")
  endtask
  task automatic t_error();
    logic [31:0] d;
    do_reset();
    @(posedge core_clk);
    park_done <= 1'b0;
    go_run(1'b0, 16'h0064, 8'h08);
    @(posedge core_clk);
    estop <= 1'b1;
    @(posedge core_clk);
    estop <= 1'b0;
    tick(2);
    host_u.send(1'b0, CMD_START, 16'h0064, 8'h08);
    #1;
    `CHK({err_mode, drive_en}, 2'b10, "early start refused")
    tick(320);
    reg_rd(REG_STATUS, d);
    `CHK({d[10:8], d[1:0]}, 5'h03, "park bound, fault and error")
    host_u.send(1'b0, CMD_START, 16'h0064, 8'h08);
    tick(2);
    `CHK({err_mode, drive_en}, 2'b10, "start ignored in error")
    do_reset();
    `CHK(err_mode, 1'b0, "power cycle clears error")
    @(posedge core_clk);
    at_zero <= 1'b0;
    host_u.send(1'b1, CMD_START, 16'h0064, 8'h08);
    host_u.send(1'b1, CMD_SET, 16'h0000, 8'h07);
    #1;
    `CHK({err_mode, drive_en, elev_tgt}, {2'b10, 8'h07}, "start off zero refused")
  endtask
  initial
  begin
    t_regs();
    t_run();
    t_lanyard();
    t_link();
    t_timeout(1'b0);
    t_timeout(1'b1);
    t_estop();
    t_error();
    complete_run();
  end
endmodule // tb_treadmill_safety_stop_supervisor
